//--- logic/tpcch_pkg.sv
// Package with register map, field positions and reset values of the timer channel
package tpcch_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_START   = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_IO      = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h0c;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_COUNTER = 8'h14;
	localparam logic [7:0] ADDR_COMPARE = 8'h18;

	// Status and interrupt enable bit positions (same layout)
	localparam int BIT_MATCH = 0;
	localparam int BIT_OVF   = 4;

	// Control register fields
	localparam int CLK_SEL_LSB = 0;
	localparam int CLK_SEL_W   = 3;
	localparam int CLR_SEL_LSB = 5;
	localparam int CLR_SEL_W   = 3;

	// Output compare level field
	localparam int OUT_SEL_LSB = 0;
	localparam int OUT_SEL_W   = 2;

	typedef enum logic [2:0] {
		TPCCH_CLR_NONE  = 3'h0,
		TPCCH_CLR_MATCH = 3'h1
	} tpcch_clr_t;

	typedef enum logic [1:0] {
		TPCCH_OUT_HOLD   = 2'h0,
		TPCCH_OUT_LOW    = 2'h1,
		TPCCH_OUT_HIGH   = 2'h2,
		TPCCH_OUT_TOGGLE = 2'h3
	} tpcch_out_t;

	// Clock select codes: 0..3 prescale by 1,4,16,64; 4 ext rising; 5 ext falling
	localparam logic [2:0] CLK_DIV1    = 3'h0;
	localparam logic [2:0] CLK_DIV4    = 3'h1;
	localparam logic [2:0] CLK_DIV16   = 3'h2;
	localparam logic [2:0] CLK_DIV64   = 3'h3;
	localparam logic [2:0] CLK_EXT_RIS = 3'h4;
	localparam logic [2:0] CLK_EXT_FAL = 3'h5;

	localparam logic [15:0] COUNT_MAX    = 16'hffff;
	localparam logic [15:0] COUNT_ZERO   = 16'h0000;
	localparam logic [15:0] COMPARE_RST  = 16'hffff;
	localparam logic [5:0]  PRESCALE_TOP = 6'h3f;

endpackage : tpcch_pkg

//--- logic/tpcch_channel.sv
// One 16-bit timer channel with free-running or periodic count, APB registers
`timescale 1ns/1ps
module tpcch_channel (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins
	input  wire logic        ext_clk_pin,
	output logic             compare_out,
	output logic             irq
);

	logic        start_q, start_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic [1:0]  io_q, io_d;
	logic [7:0]  ien_q, ien_d;
	logic        ovf_q, ovf_d;
	logic        match_q, match_d;
	logic [15:0] up_counter_q, up_counter_d;
	logic [15:0] compare_q, compare_d;
	logic        pin_q, pin_d;
	logic        irq_q, irq_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [5:0]  pre_q, pre_d;
	logic        ext_s1_q, ext_s2_q, ext_s3_q;
	logic        ext_s1_d, ext_s2_d, ext_s3_d;

	logic        wr, rd, tick, equal, fire, sel_ok;
	logic [2:0]  clk_sel;
	logic [2:0]  clr_sel;

	assign compare_out = pin_q;
	assign irq         = irq_q;
	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;

	assign clk_sel = ctrl_q[tpcch_pkg::CLK_SEL_LSB +: tpcch_pkg::CLK_SEL_W];
	assign clr_sel = ctrl_q[tpcch_pkg::CLR_SEL_LSB +: tpcch_pkg::CLR_SEL_W];

	// A write lands on the edge that samples pready high; a read is captured one
	// edge earlier so that prdata stands together with pready
	assign wr = psel && penable && pwrite && pready_q;
	assign rd = psel && penable && !pwrite && !pready_q;

	// Count clock selection, one-cycle enable
	always_comb
	begin
		pre_d = pre_q + 6'h01;
		case (clk_sel)
			tpcch_pkg::CLK_DIV1:    tick = 1'b1;
			tpcch_pkg::CLK_DIV4:    tick = (pre_q[1:0] == tpcch_pkg::PRESCALE_TOP[1:0]);
			tpcch_pkg::CLK_DIV16:   tick = (pre_q[3:0] == tpcch_pkg::PRESCALE_TOP[3:0]);
			tpcch_pkg::CLK_DIV64:   tick = (pre_q == tpcch_pkg::PRESCALE_TOP);
			tpcch_pkg::CLK_EXT_RIS: tick = ext_s2_q && !ext_s3_q;
			tpcch_pkg::CLK_EXT_FAL: tick = !ext_s2_q && ext_s3_q;
			default:                tick = 1'b0;
		endcase
		tick = tick && start_q;
	end

	// Match fires only when the equal count is about to update
	assign equal = (up_counter_q == compare_q);
	assign fire  = equal && tick;

	always_comb
	begin
		case (paddr)
			tpcch_pkg::ADDR_START, tpcch_pkg::ADDR_CONTROL, tpcch_pkg::ADDR_IO,
			tpcch_pkg::ADDR_IRQ_EN, tpcch_pkg::ADDR_STATUS, tpcch_pkg::ADDR_COUNTER,
			tpcch_pkg::ADDR_COMPARE: sel_ok = 1'b1;
			default:                 sel_ok = 1'b0;
		endcase
	end

	// Bus response: pready rises one cycle into the access phase, read data with it
	always_comb
	begin
		prdata_d  = prdata_q;
		pready_d  = psel && penable && !pready_q;
		pslverr_d = psel && penable && !pready_q && !sel_ok;
		// Unmapped reads return zero together with pslverr
		if (rd)
		begin
			case (paddr)
				tpcch_pkg::ADDR_START:   prdata_d = {31'h0, start_q};
				tpcch_pkg::ADDR_CONTROL: prdata_d = {24'h0, ctrl_q};
				tpcch_pkg::ADDR_IO:      prdata_d = {30'h0, io_q};
				tpcch_pkg::ADDR_IRQ_EN:  prdata_d = {24'h0, ien_q};
				tpcch_pkg::ADDR_STATUS:  prdata_d = {27'h0, ovf_q, 3'h0, match_q};
				tpcch_pkg::ADDR_COUNTER: prdata_d = {16'h0, up_counter_q};
				tpcch_pkg::ADDR_COMPARE: prdata_d = {16'h0, compare_q};
				default:                 prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Software-owned configuration registers
	always_comb
	begin
		start_d   = start_q;
		ctrl_d    = ctrl_q;
		io_d      = io_q;
		ien_d     = ien_q;
		compare_d = compare_q;
		// Unused upper bits of pwdata are ignored
		if (wr)
		begin
			case (paddr)
				tpcch_pkg::ADDR_START:   start_d = pwdata[0];
				tpcch_pkg::ADDR_CONTROL: ctrl_d = pwdata[7:0];
				tpcch_pkg::ADDR_IO:      io_d = pwdata[tpcch_pkg::OUT_SEL_LSB +: tpcch_pkg::OUT_SEL_W];
				tpcch_pkg::ADDR_IRQ_EN:  ien_d = pwdata[7:0];
				tpcch_pkg::ADDR_COMPARE: compare_d = pwdata[15:0];
				default:                 ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			start_q   <= 1'b0;
			ctrl_q    <= 8'h00;
			io_q      <= 2'h0;
			ien_q     <= 8'h00;
			compare_q <= tpcch_pkg::COMPARE_RST;
		end
		else
		begin
			start_q   <= start_d;
			ctrl_q    <= ctrl_d;
			io_q      <= io_d;
			ien_q     <= ien_d;
			compare_q <= compare_d;
		end
	end

	// Two flops synchronise the count pin, the third keeps its last level for edge detection
	// The prescaler free-runs, so a start write never resets its phase
	always_comb
	begin
		ext_s1_d = ext_clk_pin;
		ext_s2_d = ext_s1_q;
		ext_s3_d = ext_s2_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_q    <= 6'h00;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			pre_q    <= pre_d;
			ext_s1_q <= ext_s1_d;
			ext_s2_q <= ext_s2_d;
			ext_s3_q <= ext_s3_d;
		end
	end

	// Up-counter: a count tick in the same cycle as a software write wins
	always_comb
	begin
		up_counter_d = up_counter_q;
		if (wr && paddr == tpcch_pkg::ADDR_COUNTER)
			up_counter_d = pwdata[15:0];
		// Periodic mode clears on the matching tick, free-running wraps past the top
		if (tick)
		begin
			if (fire && clr_sel == tpcch_pkg::TPCCH_CLR_MATCH)
				up_counter_d = tpcch_pkg::COUNT_ZERO;
			else
				up_counter_d = up_counter_q + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			up_counter_q <= tpcch_pkg::COUNT_ZERO;
		else
			up_counter_q <= up_counter_d;
	end

	// Sticky flags: the software clear is applied first so a same-cycle event wins
	always_comb
	begin
		ovf_d   = ovf_q;
		match_d = match_q;
		if (wr && paddr == tpcch_pkg::ADDR_STATUS)
		begin
			if (pwdata[tpcch_pkg::BIT_OVF])
				ovf_d = 1'b0;
			if (pwdata[tpcch_pkg::BIT_MATCH])
				match_d = 1'b0;
		end
		// Overflow is the tick that takes the counter from all ones to zero
		if (tick && up_counter_q == tpcch_pkg::COUNT_MAX)
			ovf_d = 1'b1;
		// A match sets its flag in free-running mode as well
		if (fire)
			match_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_q   <= 1'b0;
			match_q <= 1'b0;
		end
		else
		begin
			ovf_q   <= ovf_d;
			match_q <= match_d;
		end
	end

	// Compare pin: the selected level is applied on the edge that carries the match
	always_comb
	begin
		pin_d = pin_q;
		// Hold keeps the pin, toggle inverts the level it shows
		if (fire)
		begin
			case (tpcch_pkg::tpcch_out_t'(io_q))
				tpcch_pkg::TPCCH_OUT_LOW:    pin_d = 1'b0;
				tpcch_pkg::TPCCH_OUT_HIGH:   pin_d = 1'b1;
				tpcch_pkg::TPCCH_OUT_TOGGLE: pin_d = !pin_q;
				default:                     pin_d = pin_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_q <= 1'b0;
		else
			pin_q <= pin_d;
	end

	// Level interrupt, one cycle behind the flags
	always_comb
	begin
		irq_d = (ovf_q && ien_q[tpcch_pkg::BIT_OVF])
			|| (match_q && ien_q[tpcch_pkg::BIT_MATCH]);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

endmodule : tpcch_channel

//--- test/tpcch_channel_properties.sv
// Port-level checks of the timer channel
`timescale 1ns/1ps
module tpcch_checker (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic        ext_clk_pin,
	input wire logic        compare_out,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray slverr");
	property p_unm; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped data");
	property p_map; pready && paddr <= tpcch_pkg::ADDR_COMPARE && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_map: assert property (p_map) else $error("mapped refused");
	property p_rst; $rose(presetn) |-> !irq && !compare_out && !pready; endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	property p_start; pready && !pwrite && paddr == tpcch_pkg::ADDR_START |-> prdata[31:1] == 31'h0;
	endproperty
	a_start: assert property (p_start) else $error("start bits");
	property p_io; pready && !pwrite && paddr == tpcch_pkg::ADDR_IO |-> prdata[31:2] == 30'h0;
	endproperty
	a_io: assert property (p_io) else $error("io bits");
	property p_mask;
		psel && penable && pready && pwrite && paddr == tpcch_pkg::ADDR_IRQ_EN && pwdata == 32'h0
		|=> ##1 !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq not masked");
endmodule : tpcch_checker
bind tpcch_channel tpcch_checker u_tpcch_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .compare_out(compare_out),
	.irq(irq));

//--- test/tb_tpcch_channel.sv
// Self-checking bench of the timer channel
`timescale 1ns/1ps
module tb_tpcch_channel;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        ext_clk_pin = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        compare_out;
	logic        irq;
	logic [31:0] rd;
	logic [31:0] sv;
	logic        er;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	always #2.5 pclk = ~pclk;
	tpcch_channel u_tpcch_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
		.compare_out(compare_out), .irq(irq));
	task end_sim;
		$display("Checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim();
		end
	end
	task cy(input int n);
		repeat (n) @(posedge pclk);
	endtask : cy
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Setup, access until pready is sampled high at a rising edge, release, one idle edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rchk
	task t_reset;
		rchk("control", tpcch_pkg::ADDR_CONTROL, 32'h0);
		rchk("compare", tpcch_pkg::ADDR_COMPARE, 32'hffff);
		cy(10);
		rchk("idle count", tpcch_pkg::ADDR_COUNTER, 32'h0);
		rchk("unmapped", 8'h1c, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
	endtask : t_reset
	task t_free;
		apb(1'b1, tpcch_pkg::ADDR_COUNTER, 32'hfff0);
		apb(1'b1, tpcch_pkg::ADDR_IRQ_EN, 32'h10);
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h1);
		cy(30);
		rchk("flags", tpcch_pkg::ADDR_STATUS, 32'h11);
		chk("ovf irq", 32'h1, {31'h0, irq});
		apb(1'b0, tpcch_pkg::ADDR_COUNTER, 32'h0);
		chk("wrapped", 32'h1, {31'h0, rd < 32'h100});
		apb(1'b1, tpcch_pkg::ADDR_STATUS, 32'h11);
		cy(2);
		chk("irq clear", 32'h0, {31'h0, irq});
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h0);
		apb(1'b0, tpcch_pkg::ADDR_COUNTER, 32'h0);
		sv = rd;
		cy(5);
		rchk("stopped", tpcch_pkg::ADDR_COUNTER, sv);
	endtask : t_free
	task t_period;
		apb(1'b1, tpcch_pkg::ADDR_COUNTER, 32'h0);
		apb(1'b1, tpcch_pkg::ADDR_COMPARE, 32'h9);
		apb(1'b1, tpcch_pkg::ADDR_CONTROL, 32'h20);
		apb(1'b1, tpcch_pkg::ADDR_IO, 32'h2);
		apb(1'b1, tpcch_pkg::ADDR_IRQ_EN, 32'h1);
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h1);
		cy(25);
		chk("pin high", 32'h1, {31'h0, compare_out});
		chk("match irq", 32'h1, {31'h0, irq});
		rchk("match only", tpcch_pkg::ADDR_STATUS, 32'h1);
		apb(1'b1, tpcch_pkg::ADDR_IRQ_EN, 32'h0);
		cy(2);
		chk("masked", 32'h0, {31'h0, irq});
		apb(1'b1, tpcch_pkg::ADDR_IO, 32'h1);
		cy(25);
		chk("pin low", 32'h0, {31'h0, compare_out});
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h0);
		apb(1'b0, tpcch_pkg::ADDR_COUNTER, 32'h0);
		chk("bounded", 32'h1, {31'h0, rd <= 32'h9});
	endtask : t_period
	// Count held equal for 64 cycles must toggle the pin once only
	task t_once;
		apb(1'b1, tpcch_pkg::ADDR_CONTROL, 32'h3);
		apb(1'b1, tpcch_pkg::ADDR_IO, 32'h3);
		apb(1'b1, tpcch_pkg::ADDR_COUNTER, 32'h0);
		apb(1'b1, tpcch_pkg::ADDR_COMPARE, 32'h1);
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h1);
		cy(160);
		chk("single toggle", 32'h1, {31'h0, compare_out});
	endtask : t_once
	task t_ext;
		for (int m = 4; m < 6; m++)
		begin
			apb(1'b1, tpcch_pkg::ADDR_START, 32'h0);
			apb(1'b1, tpcch_pkg::ADDR_CONTROL, m);
			apb(1'b1, tpcch_pkg::ADDR_COUNTER, 32'h0);
			apb(1'b1, tpcch_pkg::ADDR_START, 32'h1);
			repeat (10)
			begin
				cy(4);
				ext_clk_pin <= ~ext_clk_pin;
			end
			cy(6);
			rchk("ext count", tpcch_pkg::ADDR_COUNTER, 32'h5);
		end
	endtask : t_ext
	// A window of n + 4 cycles holds exactly (n + 4) / rate ticks, whatever the prescaler phase
	task div_run(input logic [31:0] m, input int n, input logic [31:0] e);
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h0);
		apb(1'b1, tpcch_pkg::ADDR_CONTROL, m);
		apb(1'b1, tpcch_pkg::ADDR_COUNTER, 32'h0);
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h1);
		cy(n);
		apb(1'b1, tpcch_pkg::ADDR_START, 32'h0);
		rchk("div count", tpcch_pkg::ADDR_COUNTER, e);
	endtask : div_run
	task t_div;
		div_run(32'h1, 36, 32'ha);
		div_run(32'h2, 156, 32'ha);
		div_run(32'h6, 36, 32'h0);
	endtask : t_div
	// Reset in mid-run restores the free-running defaults
	task t_rerst;
		presetn <= 1'b0;
		cy(3);
		presetn <= 1'b1;
		rchk("rerst control", tpcch_pkg::ADDR_CONTROL, 32'h0);
		rchk("rerst count", tpcch_pkg::ADDR_COUNTER, 32'h0);
		chk("rerst pin", 32'h0, {31'h0, compare_out});
	endtask : t_rerst
	initial
	begin
		cy(20);
		presetn <= 1'b1;
		t_reset();
		t_free();
		t_period();
		t_once();
		t_ext();
		t_div();
		t_rerst();
		end_sim();
	end
endmodule : tb_tpcch_channel
